/* common/nvm_port_consts.vh */
`ifndef NVM_PORT_CONSTS_VH
`define NVM_PORT_CONSTS_VH
// action select codes
`define ACT_ADDR        2'b00
`define ACT_DATA        2'b01
`define ACT_CMD         2'b10
`define ACT_IDLE        2'b11
// command bytes
`define CMD_CHIP_ERASE  8'h80
`define CMD_WR_FUSE     8'h40
`define CMD_WR_LOCK     8'h20
`define CMD_WR_FLASH    8'h10
`define CMD_WR_EEPROM   8'h11
`define CMD_RD_SIG      8'h08
`define CMD_RD_FUSELOCK 8'h04
`define CMD_RD_FLASH    8'h02
`define CMD_RD_EEPROM   8'h03
// field positions
`define FUSE_SPI_BIT    5
`define FUSE_OSC_BIT    0
`define LOCKW_TWO_BIT   2
`define LOCKW_ONE_BIT   1
`define LOCKR_ONE_BIT   7
`define LOCKR_TWO_BIT   6
// reset values
`define FUSE_SPI_RST    1'b0
`define FUSE_OSC_RST    1'b1
`define ERASED_BYTE     8'hFF
// timing
`define CLK_PERIOD_NS   20
`define ENTRY_HOLD_NS   100
`define ENTRY_HOLD_CYC  ((`ENTRY_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_TIME_NS    700000
`define PROG_TIME_CYC   (`PROG_TIME_NS / `CLK_PERIOD_NS)
`endif

/* hw/nvm_prog_port.v */
// Summary of operation
// - strobe pulse with action 00/01/10 latches address, data, command; 11 idles
// - write strobe executes latched write command: erase, fuses, locks, flash, eeprom
// - read command codes decode signature, fuse-lock, flash, eeprom
// - ready_busy_n low while programming, high when ready
// - data bus driven only while output enable low
// - byte_select picks low or high byte for flash address, data, readout
// - byte_select change within 100 ns after high level aborts entry
// - chip erase clears flash, eeprom, then locks; fuses untouched
// - chip erase is a long write pulse, ready_busy_n stays high
// - write strobe under write command programs byte, ready_busy_n low until done
// - command and address kept across many reads or writes
// - flash word address is high byte 0..1 and low byte page
// - read flash gives low byte on select low, high byte on select high
// - eeprom writes use low address 00..3F and low data byte
// - read eeprom outputs byte with output enable and select low
// - fuse write uses bit 5 and bit 0, zero programs, no busy
// - lock write uses bits 2 and 1, zero programs
// - locks return unprogrammed only through chip erase or rst_b_i reset
// - fuse-lock read maps lock one 7, lock two 6, fuses 5 and 0
// - signature read picks one of three bytes by low address
`timescale 1ns/1ps
`include "nvm_port_consts.vh"

module nvm_prog_port #(
   parameter FLASH_WORDS   = 512,
   parameter EE_BYTES      = 64,
   parameter PROG_CYCLES   = `PROG_TIME_CYC,
   parameter [7:0] SIG_B0  = 8'hA5,   // arbitrary identity value
   parameter [7:0] SIG_B1  = 8'h5A,   // arbitrary identity value
   parameter [7:0] SIG_B2  = 8'h3C    // arbitrary identity value
) (
   input  wire       core_clk_i,
   input  wire       rst_b_i,
   input  wire       hv_enable_i,
   input  wire       crystal_strobe_pin_i,
   input  wire       write_strobe_n_i,
   input  wire       output_enable_n_i,
   input  wire       byte_select_i,
   input  wire       action_select_bit0_i,
   input  wire       action_select_bit1_i,
   input  wire [7:0] data_i,
   output reg  [7:0] data_o,
   output wire       data_oe_o,
   output wire       ready_busy_n_o,
   output wire       prog_mode_o,
   output wire       serial_prog_enable_fuse_o,
   output wire       internal_osc_select_fuse_o
);

   localparam ST_IDLE  = 2'd0;
   localparam ST_PROG  = 2'd1;
   localparam ST_ERASE = 2'd2;
   localparam ENTRY_CYC = `ENTRY_HOLD_CYC;

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   reg  [13:0] sync1_ff;
   reg  [13:0] sync2_ff;
   wire [13:0] raw_in = {hv_enable_i, crystal_strobe_pin_i, write_strobe_n_i, output_enable_n_i,
                         byte_select_i, action_select_bit1_i, action_select_bit0_i, data_i[6:0]};
   reg         data7_s1_ff;
   reg         data7_s2_ff;
   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         // pin idle levels, so no false strobe or level edge after reset
         sync1_ff    <= 14'h0D80;
         sync2_ff    <= 14'h0D80;
         data7_s1_ff <= 1'b0;
         data7_s2_ff <= 1'b0;
      end else begin
         sync1_ff    <= raw_in;
         sync2_ff    <= sync1_ff;
         data7_s1_ff <= data_i[7];
         data7_s2_ff <= data7_s1_ff;
      end
   end
   wire       hv_s   = sync2_ff[13];
   wire       xs_s   = sync2_ff[12];
   wire       wr_n_s = sync2_ff[11];
   wire       oe_n_s = sync2_ff[10];
   wire       bs_s   = sync2_ff[9];
   wire [1:0] act_s  = sync2_ff[8:7];
   wire [7:0] dat_s  = {data7_s2_ff, sync2_ff[6:0]};

   // ---------------------------------------------------------------
   // programming mode entry
   // ---------------------------------------------------------------
   reg        hv_d_ff, xs_d_ff, wr_d_ff, bs_d_ff;
   reg        mode_ff;
   reg        entry_busy_ff;
   reg  [3:0] entry_cnt_ff;
   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hv_d_ff       <= 1'b0;
         xs_d_ff       <= 1'b0;
         wr_d_ff       <= 1'b1;
         bs_d_ff       <= 1'b0;
         mode_ff       <= 1'b0;
         entry_busy_ff <= 1'b0;
         entry_cnt_ff  <= 4'h0;
      end else begin
         hv_d_ff <= hv_s;
         xs_d_ff <= xs_s;
         wr_d_ff <= wr_n_s;
         bs_d_ff <= bs_s;
         if (!hv_s) begin
            mode_ff       <= 1'b0;
            entry_busy_ff <= 1'b0;
         end else if (hv_s && !hv_d_ff) begin
            // entry needs byte_select low at the high-level edge
            entry_busy_ff <= ~bs_s;
            entry_cnt_ff  <= 4'h0;
         end else if (entry_busy_ff) begin
            if (bs_s != bs_d_ff) begin
               entry_busy_ff <= 1'b0;
            end else if (entry_cnt_ff == ENTRY_CYC[3:0]) begin
               entry_busy_ff <= 1'b0;
               mode_ff       <= 1'b1;
            end else begin
               entry_cnt_ff <= entry_cnt_ff + 4'h1;
            end
         end
      end
   end
   assign prog_mode_o = mode_ff;

   // ---------------------------------------------------------------
   // holders, memories and sequencer
   // ---------------------------------------------------------------
   reg [7:0]  cmd_ff, addr_lo_ff, addr_hi_ff, data_lo_ff, data_hi_ff;
   reg        fuse_spi_ff, fuse_osc_ff, lock_one_ff, lock_two_ff;
   reg [1:0]  state_ff;
   reg [19:0] cnt_ff;
   reg [9:0]  wipe_ff;
   reg [7:0]  flash_lo [0:FLASH_WORDS-1];
   reg [7:0]  flash_hi [0:FLASH_WORDS-1];
   reg [7:0]  eeprom   [0:EE_BYTES-1];

   // word address from high and low bytes
   wire [8:0] word_addr = {addr_hi_ff[0], addr_lo_ff};
   wire [5:0] ee_addr   = addr_lo_ff[5:0];
   wire       xs_rise   = xs_s & ~xs_d_ff;
   wire       wr_fall   = ~wr_n_s & wr_d_ff;
   wire       wr_rise   = wr_n_s & ~wr_d_ff;
   wire       write_lock = ~lock_one_ff;

   function is_write_cmd;
      input [7:0] c;
      begin
         is_write_cmd = (c == `CMD_WR_FLASH) || (c == `CMD_WR_EEPROM);
      end
   endfunction

   always @(posedge core_clk_i) begin
      // arrays wiped word by word before locks release
      if (state_ff == ST_ERASE) begin
         flash_lo[wipe_ff[8:0]] <= `ERASED_BYTE;
         flash_hi[wipe_ff[8:0]] <= `ERASED_BYTE;
         if (wipe_ff < EE_BYTES)
            eeprom[wipe_ff[5:0]] <= `ERASED_BYTE;
      end else if (mode_ff && state_ff == ST_IDLE && wr_fall && is_write_cmd(cmd_ff) && !write_lock) begin
         // select picks flash byte; eeprom low address and data
         if (cmd_ff == `CMD_WR_EEPROM)
            eeprom[ee_addr] <= data_lo_ff;
         else if (bs_s)
            flash_hi[word_addr] <= data_hi_ff;
         else
            flash_lo[word_addr] <= data_lo_ff;
      end
   end

   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmd_ff      <= 8'h00;
         addr_lo_ff  <= 8'h00;
         addr_hi_ff  <= 8'h00;
         data_lo_ff  <= `ERASED_BYTE;
         data_hi_ff  <= `ERASED_BYTE;
         fuse_spi_ff <= `FUSE_SPI_RST;
         fuse_osc_ff <= `FUSE_OSC_RST;
         lock_one_ff <= 1'b1;
         lock_two_ff <= 1'b1;
         state_ff    <= ST_IDLE;
         cnt_ff      <= 20'h0_0000;
         wipe_ff     <= 10'h000;
      end else begin
         // strobe edge samples action, select, data; action decode
         if (mode_ff && xs_rise) begin
            case (act_s)
               `ACT_ADDR: begin
                  if (bs_s) addr_hi_ff <= dat_s;
                  else      addr_lo_ff <= dat_s;
               end
               `ACT_DATA: begin
                  if (bs_s) data_hi_ff <= dat_s;
                  else      data_lo_ff <= dat_s;
               end
               `ACT_CMD:  cmd_ff <= dat_s;
               default: ;
            endcase
         end
         case (state_ff)
            ST_IDLE: begin
               // write strobe executes latched command; holders kept
               if (mode_ff && wr_fall) begin
                  if (cmd_ff == `CMD_CHIP_ERASE) begin
                     state_ff <= ST_ERASE;
                     wipe_ff  <= 10'h000;
                  // byte programming, busy asserted; locked writes skip
                  end else if (is_write_cmd(cmd_ff) && !write_lock) begin
                     state_ff <= ST_PROG;
                     cnt_ff   <= 20'h0_0000;
                  end
               end
               // fuse byte taken at end of long pulse; fuses locked too
               if (mode_ff && wr_rise && cmd_ff == `CMD_WR_FUSE && !write_lock) begin
                  fuse_spi_ff <= data_lo_ff[`FUSE_SPI_BIT];
                  fuse_osc_ff <= data_lo_ff[`FUSE_OSC_BIT];
               end
               // lock bits; can only be programmed here
               if (mode_ff && wr_fall && cmd_ff == `CMD_WR_LOCK) begin
                  lock_one_ff <= lock_one_ff & data_lo_ff[`LOCKW_ONE_BIT];
                  lock_two_ff <= lock_two_ff & data_lo_ff[`LOCKW_TWO_BIT];
               end
            end
            ST_PROG: begin
               if (cnt_ff >= PROG_CYCLES[19:0] - 20'h0_0001)
                  state_ff <= ST_IDLE;
               else
                  cnt_ff <= cnt_ff + 20'h0_0001;
            end
            ST_ERASE: begin
               // locks released after arrays fully wiped, fuses untouched
               if (wipe_ff == FLASH_WORDS[9:0] - 10'h001) begin
                  lock_one_ff <= 1'b1;
                  lock_two_ff <= 1'b1;
                  state_ff    <= ST_IDLE;
               end else begin
                  wipe_ff <= wipe_ff + 10'h001;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // erase and fuse writes leave busy high; low only while programming
   assign ready_busy_n_o = (state_ff != ST_PROG);
   assign serial_prog_enable_fuse_o  = fuse_spi_ff;
   assign internal_osc_select_fuse_o = fuse_osc_ff;

   // ---------------------------------------------------------------
   // readout
   // ---------------------------------------------------------------
   // verify is barred when both lock bits are programmed
   wire verify_lock = ~lock_one_ff & ~lock_two_ff;
   reg [7:0] nxt_data;
   always @* begin
      nxt_data = 8'h00;
      case (cmd_ff)
         `CMD_RD_FLASH:
            if (!verify_lock)
               nxt_data = bs_s ? flash_hi[word_addr] : flash_lo[word_addr];
         `CMD_RD_EEPROM:
            if (!verify_lock && !bs_s)
               nxt_data = eeprom[ee_addr];
         // fuse and lock map on select high
         `CMD_RD_FUSELOCK:
            if (bs_s) begin
               nxt_data = 8'h3E;
               nxt_data[`LOCKR_ONE_BIT] = lock_one_ff;
               nxt_data[`LOCKR_TWO_BIT] = lock_two_ff;
               nxt_data[`FUSE_SPI_BIT]  = fuse_spi_ff;
               nxt_data[`FUSE_OSC_BIT]  = fuse_osc_ff;
            end
         // signature by low address; read decode
         `CMD_RD_SIG:
            if (!bs_s)
               case (addr_lo_ff)
                  8'h00:   nxt_data = SIG_B0;
                  8'h01:   nxt_data = SIG_B1;
                  8'h02:   nxt_data = SIG_B2;
                  default: nxt_data = 8'h00;
               endcase
         default: nxt_data = 8'h00;
      endcase
   end

   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         data_o <= 8'h00;
      else
         data_o <= nxt_data;
   end
   // drive bus only while output enable low
   assign data_oe_o = mode_ff & ~oe_n_s;

endmodule // nvm_prog_port

/* test/nvm_prog_port_props.sv */
`timescale 1ns/1ps
module nvm_prog_port_props #(
   parameter PROG_CYCLES = 20
) (
   input wire core_clk_i,
   input wire rst_b_i,
   input wire hv_enable_i,
   input wire write_strobe_n_i,
   input wire output_enable_n_i,
   input wire byte_select_i,
   input wire data_oe_o,
   input wire ready_busy_n_o,
   input wire prog_mode_o,
   input wire serial_prog_enable_fuse_o,
   input wire internal_osc_select_fuse_o
);
   reg [31:0] busy_cnt_ff;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   // length of the busy window, compared when ready returns
   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) busy_cnt_ff <= 32'h0000_0000;
      else busy_cnt_ff <= ready_busy_n_o ? 32'h0000_0000 : busy_cnt_ff + 32'h0000_0001;
   end
   rst_vals_a: assert property ($rose(rst_b_i) |-> ready_busy_n_o && !prog_mode_o && !data_oe_o
      && !serial_prog_enable_fuse_o && internal_osc_select_fuse_o) else $error("bad values after reset");
   entry_cond_a: assert property ($rose(prog_mode_o) |-> $past(hv_enable_i, 4) && !$past(byte_select_i, 4))
      else $error("mode entered without a clean entry");
   mode_exit_a: assert property (!hv_enable_i [*5] |-> !prog_mode_o)
      else $error("mode kept without high level");
   oe_off_a: assert property (output_enable_n_i [*5] |-> !data_oe_o)
      else $error("bus driven with output enable high");
   oe_on_a: assert property ((prog_mode_o && !output_enable_n_i) [*5] |-> data_oe_o)
      else $error("bus not driven with output enable low");
   oe_mode_a: assert property (data_oe_o |-> !$past(output_enable_n_i, 2) && prog_mode_o)
      else $error("bus driven outside programming mode");
   busy_cause_a: assert property ($fell(ready_busy_n_o) |-> !$past(write_strobe_n_i, 2) && prog_mode_o)
      else $error("busy without a write strobe");
   busy_len_a: assert property ($rose(ready_busy_n_o) |-> busy_cnt_ff == PROG_CYCLES)
      else $error("busy window has wrong length");
   fuse_change_a: assert property (!$stable({serial_prog_enable_fuse_o, internal_osc_select_fuse_o})
      |-> $past(write_strobe_n_i, 1) && !$past(write_strobe_n_i, 8)) else $error("fuse changed without write");
endmodule // nvm_prog_port_props

/* test/nvm_programmer_model.sv */
`timescale 1ns/1ps
module nvm_programmer_model (
   input  wire       core_clk_i,
   input  wire       ready_busy_n_i,
   input  wire       data_oe_i,
   input  wire [7:0] dev_data_i,
   output reg        hv_enable_o,
   output reg        strobe_o,
   output reg        write_n_o,
   output reg        oe_n_o,
   output reg        bs_o,
   output reg  [1:0] act_o,
   output wire [7:0] bus_o
);
   reg [7:0] drv_ff;
   // released bus shows the inverse of the last value, never a stale copy
   assign bus_o = data_oe_i ? dev_data_i : (oe_n_o ? drv_ff : ~drv_ff);
   initial begin
      hv_enable_o = 1'b0;
      strobe_o = 1'b0;
      write_n_o = 1'b1;
      oe_n_o = 1'b1;
      bs_o = 1'b0;
      act_o = 2'b11;
      drv_ff = 8'h00;
   end
   task cyc(input integer n);
      repeat (n) @(negedge core_clk_i);
   endtask
   task enter;
      begin
         bs_o = 1'b0;
         cyc(6);
         hv_enable_o = 1'b1;
         cyc(8);
      end
   endtask
   task load(input [1:0] a, input b, input [7:0] d);
      begin
         act_o = a;
         bs_o = b;
         drv_ff = d;
         cyc(4);
         strobe_o = 1'b1;
         cyc(4);
         strobe_o = 1'b0;
         cyc(4);
         act_o = 2'b11;
      end
   endtask
   // wait for ready before the next write
   task wr(input b, input integer w);
      begin
         bs_o = b;
         cyc(3);
         write_n_o = 1'b0;
         cyc(w);
         write_n_o = 1'b1;
         cyc(6);
         // a device that never returns ready falls to the bench watchdog
         while (ready_busy_n_i !== 1'b1) cyc(1);
         cyc(3);
      end
   endtask
   task rd(input b, output [7:0] q);
      begin
         bs_o = b;
         oe_n_o = 1'b0;
         cyc(6);
         q = data_oe_i ? dev_data_i : 8'hxx;
         oe_n_o = 1'b1;
         cyc(4);
      end
   endtask
   // dropping the high level leaves the mode
   task leave;
      begin
         hv_enable_o = 1'b0;
         cyc(6);
      end
   endtask
endmodule // nvm_programmer_model

/* test/nvm_prog_port_tb.sv */
`timescale 1ns/1ps
`include "nvm_port_consts.vh"
`define CHK(a, e) begin total_checks = total_checks + 1; if ((a) !== (e)) begin err_count = err_count + 1; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module nvm_prog_port_tb;
   localparam        PROG_CYCLES = 20;
   localparam [23:0] SIGS        = 24'h3C_5AA5; // arbitrary identity values
   reg               core_clk_i;
   reg               rst_b_i;
   reg               bsy_seen;
   reg  [7:0]        q;
   integer           err_count;
   integer           total_checks;
   integer           i;
   wire              hv, stb, wr_n, oe_n, bs, rdy, oe, mode, spi, osc;
   wire [1:0]        act;
   wire [7:0]        bus;
   wire [7:0]        dout;
   nvm_prog_port #(.PROG_CYCLES(PROG_CYCLES), .SIG_B0(SIGS[7:0]), .SIG_B1(SIGS[15:8]), .SIG_B2(SIGS[23:16])) i_dut (
      .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .hv_enable_i(hv), .crystal_strobe_pin_i(stb),
      .write_strobe_n_i(wr_n), .output_enable_n_i(oe_n), .byte_select_i(bs), .action_select_bit0_i(act[0]),
      .action_select_bit1_i(act[1]), .data_i(bus), .data_o(dout), .data_oe_o(oe), .ready_busy_n_o(rdy),
      .prog_mode_o(mode), .serial_prog_enable_fuse_o(spi), .internal_osc_select_fuse_o(osc));
   nvm_programmer_model i_prog (.core_clk_i(core_clk_i), .ready_busy_n_i(rdy), .data_oe_i(oe), .dev_data_i(dout),
      .hv_enable_o(hv), .strobe_o(stb), .write_n_o(wr_n), .oe_n_o(oe_n), .bs_o(bs), .act_o(act), .bus_o(bus));
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) if (rdy === 1'b0) bsy_seen = 1'b1;
   task cmd(input [7:0] c); i_prog.load(`ACT_CMD, 1'b0, c); endtask
   task adr(input b, input [7:0] d); i_prog.load(`ACT_ADDR, b, d); endtask
   task dat(input b, input [7:0] d); i_prog.load(`ACT_DATA, b, d); endtask
   task rdc(input b, input [7:0] e);
      begin
         i_prog.rd(b, q);
         `CHK(q, e)
      end
   endtask
   // write that must leave ready high throughout
   task wq(input [7:0] d, input integer w);
      begin
         dat(1'b0, d);
         bsy_seen = 1'b0;
         i_prog.wr(1'b0, w);
         `CHK(bsy_seen, 1'b0)
      end
   endtask
   task final_report;
      begin
         if (err_count == 0 && total_checks > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   initial begin
      repeat (20000) @(posedge core_clk_i);
      err_count = err_count + 1;
      final_report;
   end
   initial begin
      rst_b_i = 1'b0;
      bsy_seen = 1'b0;
      err_count = 0;
      total_checks = 0;
      repeat (4) @(negedge core_clk_i);
      `CHK({rdy, mode, oe, spi, osc}, 5'h11)
      rst_b_i = 1'b1;
      i_prog.enter;
      for (i = 0; i < 40 && mode !== 1'b1; i = i + 1) @(negedge core_clk_i);
      `CHK(mode, 1'b1)
      cmd(`CMD_CHIP_ERASE);
      bsy_seen = 1'b0;
      i_prog.wr(1'b0, 600);
      `CHK(bsy_seen, 1'b0)
      cmd(`CMD_RD_EEPROM);
      adr(1'b0, 8'h3F);
      rdc(1'b0, `ERASED_BYTE);
      cmd(`CMD_WR_FLASH);
      adr(1'b1, 8'h01);
      adr(1'b0, 8'h05);
      dat(1'b0, 8'h34);
      bsy_seen = 1'b0;
      i_prog.wr(1'b0, 8);
      `CHK(bsy_seen, 1'b1)
      dat(1'b1, 8'h12);
      i_prog.wr(1'b1, 8);
      adr(1'b1, 8'h00);
      dat(1'b0, 8'h56);
      i_prog.wr(1'b0, 8);
      cmd(`CMD_RD_FLASH);
      i_prog.load(`ACT_IDLE, 1'b0, `CMD_CHIP_ERASE);
      adr(1'b1, 8'h01);
      rdc(1'b0, 8'h34);
      rdc(1'b1, 8'h12);
      adr(1'b1, 8'h00);
      rdc(1'b0, 8'h56);
      rdc(1'b1, `ERASED_BYTE);
      cmd(`CMD_WR_EEPROM);
      dat(1'b0, 8'hA7);
      i_prog.wr(1'b0, 8);
      cmd(`CMD_RD_EEPROM);
      rdc(1'b0, 8'hA7);
      cmd(`CMD_RD_SIG);
      for (i = 0; i < 3; i = i + 1) begin
         adr(1'b0, i[7:0]);
         rdc(1'b0, SIGS[i*8 +: 8]);
      end
      cmd(`CMD_WR_FUSE);
      wq(8'hFE, 40);
      `CHK({spi, osc}, 2'b10)
      cmd(`CMD_RD_FUSELOCK);
      rdc(1'b1, 8'hFE);
      cmd(`CMD_WR_LOCK);
      dat(1'b0, 8'hFD);
      i_prog.wr(1'b0, 8);
      cmd(`CMD_WR_FLASH);
      adr(1'b0, 8'h05);
      wq(8'h00, 8);
      cmd(`CMD_WR_FUSE);
      wq(8'hFF, 40);
      `CHK({spi, osc}, 2'b10)
      cmd(`CMD_RD_FLASH);
      rdc(1'b0, 8'h56);
      cmd(`CMD_WR_LOCK);
      dat(1'b0, 8'hFB);
      i_prog.wr(1'b0, 8);
      dat(1'b0, 8'hFF);
      i_prog.wr(1'b0, 8);
      cmd(`CMD_RD_FUSELOCK);
      rdc(1'b1, 8'h3E);
      cmd(`CMD_CHIP_ERASE);
      i_prog.wr(1'b0, 600);
      cmd(`CMD_RD_FUSELOCK);
      rdc(1'b1, 8'hFE);
      cmd(`CMD_RD_FLASH);
      rdc(1'b0, `ERASED_BYTE);
      i_prog.leave;
      `CHK(mode, 1'b0)
      final_report;
   end
endmodule // nvm_prog_port_tb
bind nvm_prog_port nvm_prog_port_props #(.PROG_CYCLES(PROG_CYCLES)) i_props (.core_clk_i(core_clk_i),
   .rst_b_i(rst_b_i), .hv_enable_i(hv_enable_i), .write_strobe_n_i(write_strobe_n_i),
   .output_enable_n_i(output_enable_n_i), .byte_select_i(byte_select_i), .data_oe_o(data_oe_o),
   .ready_busy_n_o(ready_busy_n_o), .prog_mode_o(prog_mode_o), .serial_prog_enable_fuse_o(serial_prog_enable_fuse_o),
   .internal_osc_select_fuse_o(internal_osc_select_fuse_o));
